// ---- design/ctw_top.v ----
// general capture timer and 16-bit watchdog timer behind an AXI4-Lite
// slave. assumes the chip reset output is fed back into rst_n.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
`include "ctw_regs.vh"
module ctw_top #(
   parameter NUM_SOURCES = 34
) (
   // clock and reset
   input  wire                   clk_sys,
   input  wire                   rst_n,
   // axi4-lite write
   input  wire [31:0]            s_axi_awaddr,
   input  wire [2:0]             s_axi_awprot,
   input  wire                   s_axi_awvalid,
   output wire                   s_axi_awready,
   input  wire [31:0]            s_axi_wdata,
   input  wire [3:0]             s_axi_wstrb,
   input  wire                   s_axi_wvalid,
   output wire                   s_axi_wready,
   output reg  [1:0]             s_axi_bresp,
   output reg                    s_axi_bvalid,
   input  wire                   s_axi_bready,
   // axi4-lite read
   input  wire [31:0]            s_axi_araddr,
   input  wire [2:0]             s_axi_arprot,
   input  wire                   s_axi_arvalid,
   output wire                   s_axi_arready,
   output reg  [31:0]            s_axi_rdata,
   output reg  [1:0]             s_axi_rresp,
   output reg                    s_axi_rvalid,
   input  wire                   s_axi_rready,
   // count sources from pins
   input  wire                   xtal_32k_in,
   input  wire                   undivided_system_clock,
   input  wire                   external_count_pin,
   // interrupt sources, same clock domain
   input  wire [NUM_SOURCES-1:0] event_sources,
   // outputs
   output reg                    gt_irq_q,
   output reg                    wd_irq_q,
   output reg                    wd_chip_reset_q
);

   reg [31:0] aw_addr_q;
   reg        aw_full_q;
   reg [31:0] wdata_q;
   reg [3:0]  wstrb_q;
   reg        w_full_q;
   reg [31:0] rd_mux;
   reg        rd_hit;
   reg [31:0] gt_con_q;
   reg [31:0] gt_load_q;
   reg [31:0] gt_val_q;
   reg [31:0] gt_val_d;
   reg [31:0] gt_cap_q;
   reg [14:0] gt_pre_q;
   reg        gt_src_tick;
   reg        gt_wrap;
   reg [NUM_SOURCES-1:0] evt_prev_q;
   reg [15:0] wd_con_q;
   reg [15:0] wd_load_q;
   reg [15:0] wd_val_q;
   reg [7:0]  wd_pre_q;
   reg [7:0]  lfsr_q;
   wire       xtal_rise;
   wire       undivided_system_clock_rise;
   wire       pin_rise;

   ////////////////////////////////////////////////////////////////////////
   // helpers
   function [14:0] gt_pre_limit;
      input [3:0] code;
      begin
         case (code)
            `CTW_GT_PRE_16:  gt_pre_limit = `CTW_GT_LIM_16;
            `CTW_GT_PRE_256: gt_pre_limit = `CTW_GT_LIM_256;
            `CTW_GT_PRE_32K: gt_pre_limit = `CTW_GT_LIM_32K;
            default:         gt_pre_limit = `CTW_GT_LIM_1;
         endcase
      end
   endfunction

   function [7:0] wd_pre_limit;
      input [1:0] code;
      begin
         case (code)
            `CTW_WD_PRE_16:  wd_pre_limit = `CTW_WD_LIM_16;
            `CTW_WD_PRE_256: wd_pre_limit = `CTW_WD_LIM_256;
            default:         wd_pre_limit = `CTW_WD_LIM_1;
         endcase
      end
   endfunction

   // one step of the hours:minutes:seconds:hundredths count
   function [31:0] hms_step;
      input [31:0] v;
      input        up;
      input [7:0]  hmax;
      reg   [7:0]  h, m, s, c;
      begin
         h = v[31:24];
         m = v[23:16];
         s = v[15:8];
         c = v[7:0];
         if (up) begin
            if (c != `CTW_HUND_MAX) c = c + 8'h01;
            else begin
               c = 8'h00;
               if (s != `CTW_SEC_MAX) s = s + 8'h01;
               else begin
                  s = 8'h00;
                  if (m != `CTW_SEC_MAX) m = m + 8'h01;
                  else begin
                     m = 8'h00;
                     h = (h == hmax) ? 8'h00 : h + 8'h01;
                  end
               end
            end
         end else begin
            if (c != 8'h00) c = c - 8'h01;
            else begin
               c = `CTW_HUND_MAX;
               if (s != 8'h00) s = s - 8'h01;
               else begin
                  s = `CTW_SEC_MAX;
                  if (m != 8'h00) m = m - 8'h01;
                  else begin
                     m = `CTW_SEC_MAX;
                     h = (h == 8'h00) ? hmax : h - 8'h01;
                  end
               end
            end
         end
         hms_step = {h, m, s, c};
      end
   endfunction

   function [7:0] lfsr_next;
      input [7:0] v;
      begin
         lfsr_next = {v[6:0], 1'b0} ^ (v[7] ? `CTW_LFSR_TAPS : 8'h00);
      end
   endfunction

   function [31:0] strb_merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  strb;
      integer      i;
      begin
         strb_merge = old;
         for (i = 0; i < 4; i = i + 1)
            if (strb[i]) strb_merge[i*8 +: 8] = nw[i*8 +: 8];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // pin sources are synchronised; each gives a one-cycle rising pulse
   ctw_edge_sync u_sync_xtal (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .async_in (xtal_32k_in),
      .rise_q   (xtal_rise)
   );

   ctw_edge_sync u_sync_undivided_system_clock (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .async_in (undivided_system_clock),
      .rise_q   (undivided_system_clock_rise)
   );

   ctw_edge_sync u_sync_pin (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .async_in (external_count_pin),
      .rise_q   (pin_rise)
   );

   ////////////////////////////////////////////////////////////////////////
   // axi4-lite write: address and data taken in either order
   wire wr_hit = (aw_addr_q == `CTW_ADDR_GT_LOAD) ||
                 (aw_addr_q == `CTW_ADDR_GT_VAL)  ||
                 (aw_addr_q == `CTW_ADDR_GT_CON)  ||
                 (aw_addr_q == `CTW_ADDR_GT_CLR)  ||
                 (aw_addr_q == `CTW_ADDR_GT_CAP)  ||
                 (aw_addr_q == `CTW_ADDR_WD_LOAD) ||
                 (aw_addr_q == `CTW_ADDR_WD_VAL)  ||
                 (aw_addr_q == `CTW_ADDR_WD_CON)  ||
                 (aw_addr_q == `CTW_ADDR_WD_CLR);
   wire wr_fire = aw_full_q & w_full_q & ~s_axi_bvalid;
   assign s_axi_awready = ~aw_full_q;
   assign s_axi_wready  = ~w_full_q;

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         aw_addr_q    <= 32'h00000000;
         aw_full_q    <= 1'b0;
         wdata_q      <= 32'h00000000;
         wstrb_q      <= 4'h0;
         w_full_q     <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `CTW_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_full_q) begin
            aw_addr_q <= s_axi_awaddr;
            aw_full_q <= 1'b1;
         end else if (wr_fire) begin
            aw_full_q <= 1'b0;
         end
         if (s_axi_wvalid && !w_full_q) begin
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
            w_full_q <= 1'b1;
         end else if (wr_fire) begin
            w_full_q <= 1'b0;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `CTW_RESP_OKAY : `CTW_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // strobes of the individual registers
   wire wd_mode    = wd_con_q[`CTW_WD_MODE];
   wire wr_gt_load = wr_fire & (aw_addr_q == `CTW_ADDR_GT_LOAD);
   wire wr_gt_con  = wr_fire & (aw_addr_q == `CTW_ADDR_GT_CON);
   wire wr_gt_clr  = wr_fire & (aw_addr_q == `CTW_ADDR_GT_CLR);
   wire wr_wd_load = wr_fire & (aw_addr_q == `CTW_ADDR_WD_LOAD)
                     & ~wd_mode;
   wire wr_wd_con  = wr_fire & (aw_addr_q == `CTW_ADDR_WD_CON)
                     & ~wd_mode;
   wire wr_wd_clr  = wr_fire & (aw_addr_q == `CTW_ADDR_WD_CLR);
   wire [31:0] wr_merged_gt_con  = strb_merge(gt_con_q, wdata_q, wstrb_q);
   wire [31:0] wr_merged_gt_load = strb_merge(gt_load_q, wdata_q, wstrb_q);
   wire [31:0] wr_merged_wd_con  =
      strb_merge({16'h0000, wd_con_q}, wdata_q, wstrb_q);
   wire [31:0] wr_merged_wd_load =
      strb_merge({16'h0000, wd_load_q}, wdata_q, wstrb_q);

   ////////////////////////////////////////////////////////////////////////
   // axi4-lite read: data registered one cycle after the address
   assign s_axi_arready = ~s_axi_rvalid;

   always @* begin
      rd_hit = 1'b1;
      case (s_axi_araddr)
         `CTW_ADDR_GT_LOAD: rd_mux = gt_load_q;
         `CTW_ADDR_GT_VAL:  rd_mux = gt_val_q;
         `CTW_ADDR_GT_CON:  rd_mux = gt_con_q;
         `CTW_ADDR_GT_CAP:  rd_mux = gt_cap_q;
         `CTW_ADDR_WD_LOAD: rd_mux = {16'h0000, wd_load_q};
         `CTW_ADDR_WD_VAL:  rd_mux = {16'h0000, wd_val_q};
         `CTW_ADDR_WD_CON:  rd_mux = {16'h0000, wd_con_q};
         `CTW_ADDR_GT_CLR:  rd_mux = 32'h00000000;
         `CTW_ADDR_WD_CLR:  rd_mux = 32'h00000000;  // lfsr stays hidden
         default: begin
            rd_mux = 32'h00000000;
            rd_hit = 1'b0;
         end
      endcase
   end

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `CTW_RESP_OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_mux;
         s_axi_rresp  <= rd_hit ? `CTW_RESP_OKAY : `CTW_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // general timer: source select and prescaler
   wire [2:0]  gt_src   = gt_con_q[`CTW_GT_SRC_HI:`CTW_GT_SRC_LO];
   wire [1:0]  gt_fmt   = gt_con_q[`CTW_GT_FMT_HI:`CTW_GT_FMT_LO];
   wire        gt_up    = gt_con_q[`CTW_GT_UP];
   wire        gt_hms   = gt_fmt[1];  // 01 reserved, counts binary
   wire [7:0]  gt_hmax  = (gt_fmt == `CTW_FMT_HMS23) ? `CTW_HOUR_23
                                                     : `CTW_HOUR_255;
   wire [14:0] gt_limit =
      gt_pre_limit(gt_con_q[`CTW_GT_PRE_HI:`CTW_GT_PRE_LO]);
   wire [31:0] gt_full  = gt_hms ? {gt_hmax, `CTW_SEC_MAX, `CTW_SEC_MAX,
                                    `CTW_HUND_MAX} : 32'hffffffff;
   wire        gt_tick  = gt_con_q[`CTW_GT_EN] & gt_src_tick &
                          (gt_pre_q >= gt_limit);

   always @* begin
      case (gt_src)
         `CTW_SRC_CORE: gt_src_tick = 1'b1;
         `CTW_SRC_XTAL: gt_src_tick = xtal_rise;
         `CTW_SRC_UNDIVIDED_SYSTEM_CLOCK: gt_src_tick = undivided_system_clock_rise;
         `CTW_SRC_PIN:  gt_src_tick = pin_rise;
         default:       gt_src_tick = 1'b0;
      endcase
   end

   // next count; a wrap is the zero or full scale point of the direction
   always @* begin
      gt_wrap  = 1'b0;
      gt_val_d = gt_val_q;
      if (gt_up && gt_val_q == gt_full) begin
         gt_wrap  = 1'b1;
         gt_val_d = gt_con_q[`CTW_GT_PER] ? gt_load_q
                                          : 32'h00000000;
      end else if (!gt_up && gt_val_q == 32'h00000000) begin
         gt_wrap  = 1'b1;
         gt_val_d = gt_con_q[`CTW_GT_PER] ? gt_load_q : gt_full;
      end else if (gt_hms) begin
         gt_val_d = hms_step(gt_val_q, gt_up, gt_hmax);
      end else begin
         gt_val_d = gt_up ? gt_val_q + 32'h00000001
                          : gt_val_q - 32'h00000001;
      end
   end

   // event select, offset by two into the source list
   wire [5:0] gt_evt_idx = {1'b0, gt_con_q[`CTW_GT_EVT_HI:`CTW_GT_EVT_LO]}
                           + `CTW_EVT_OFFSET;
   wire [NUM_SOURCES-1:0] evt_rise = event_sources & ~evt_prev_q;
   wire gt_capture = gt_con_q[`CTW_GT_CAP_EN] & evt_rise[gt_evt_idx];

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         gt_con_q   <= `CTW_RST_GT_CON;
         gt_load_q  <= `CTW_RST_GT_LOAD;
         gt_val_q   <= `CTW_RST_GT_VAL;
         gt_cap_q   <= `CTW_RST_GT_CAP;
         gt_pre_q   <= 15'h0000;
         gt_irq_q   <= 1'b0;
         evt_prev_q <= {NUM_SOURCES{1'b0}};
      end else begin
         evt_prev_q <= event_sources;
         if (wr_gt_con)
            gt_con_q <= wr_merged_gt_con & `CTW_GT_CON_MASK;
         if (wr_gt_load)
            gt_load_q <= wr_merged_gt_load;
         // a load write also restarts the count from the new value
         if (wr_gt_load)
            gt_val_q <= wr_merged_gt_load;
         else if (gt_tick)
            gt_val_q <= gt_val_d;
         if (!gt_con_q[`CTW_GT_EN])
            gt_pre_q <= 15'h0000;
         else if (gt_tick)
            gt_pre_q <= 15'h0000;
         else if (gt_src_tick)
            gt_pre_q <= gt_pre_q + 15'h0001;
         if (gt_capture)
            gt_cap_q <= gt_val_q;
         // a wrap in the clearing cycle wins over the clear
         gt_irq_q <= (gt_tick & gt_wrap) |
                     (gt_irq_q & ~wr_gt_clr);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // second timer: always clocked by the crystal, prescaled 1/16/256
   wire [7:0] wd_limit =
      wd_pre_limit(wd_con_q[`CTW_WD_PRE_HI:`CTW_WD_PRE_LO]);
   wire wd_run  = wd_mode | wd_con_q[`CTW_WD_EN];
   wire wd_tick = wd_run & xtal_rise &
                  (wd_pre_q >= wd_limit);
   wire wd_up   = wd_con_q[`CTW_WD_UP] & ~wd_mode;
   wire wd_sec  = wd_con_q[`CTW_WD_SEC];
   // a zero seed never matches, so it always resets
   wire wd_match    = (wdata_q[7:0] == lfsr_q) &
                      (lfsr_q != 8'h00);
   wire wd_svc_ok   = wd_mode & wr_wd_clr & (~wd_sec | wd_match);
   wire wd_svc_bad  = wd_mode & wr_wd_clr & wd_sec & ~wd_match;
   wire wd_expire   = wd_mode & wd_tick & (wd_val_q == 16'h0000);
   wire wd_nrm_wrap = ~wd_mode & wd_tick &
                      (wd_up ? (wd_val_q == 16'hffff)
                             : (wd_val_q == 16'h0000));
   wire wd_enter    = wr_wd_con & wr_merged_wd_con[`CTW_WD_MODE];

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         wd_con_q        <= `CTW_RST_WD_CON;
         wd_load_q       <= `CTW_RST_WD_LOAD;
         wd_val_q        <= `CTW_RST_WD_VAL;
         wd_pre_q        <= 8'h00;
         lfsr_q          <= 8'h00;
         wd_irq_q        <= 1'b0;
         wd_chip_reset_q <= 1'b0;
      end else begin
         if (wr_wd_con)
            wd_con_q <= wr_merged_wd_con[15:0] & `CTW_WD_CON_MASK;
         if (wr_wd_load)
            wd_load_q <= wr_merged_wd_load[15:0];
         if (!wd_run || wd_tick)
            wd_pre_q <= 8'h00;
         else if (xtal_rise)
            wd_pre_q <= wd_pre_q + 8'h01;
         // counter: entry and service reload, then ticks
         if (wr_wd_load)
            wd_val_q <= wr_merged_wd_load[15:0];
         else if (wd_enter || wd_svc_ok)
            wd_val_q <= wd_load_q;
         else if (wd_expire)
            wd_val_q <= wd_load_q;  // irq option restarts the timeout
         else if (wd_mode && wd_tick)
            wd_val_q <= wd_val_q - 16'h0001;
         else if (wd_nrm_wrap)
            wd_val_q <= wd_con_q[`CTW_WD_PER] ? wd_load_q :
                        (wd_up ? 16'h0000 : 16'hffff);
         else if (wd_tick)
            wd_val_q <= wd_up ? wd_val_q + 16'h0001
                              : wd_val_q - 16'h0001;
         // seed before entry, advance on each accepted secure clear
         if (wr_wd_clr && !wd_mode)
            lfsr_q <= wdata_q[7:0];
         else if (wd_svc_ok && wd_sec)
            lfsr_q <= lfsr_next(lfsr_q);
         // irq: set wins over the clear write
         wd_irq_q <= wd_nrm_wrap |
                     (wd_expire & wd_con_q[`CTW_WD_IRQOPT]) |
                     (wd_irq_q & ~wr_wd_clr);
         // held until the chip reset comes back on rst_n
         if ((wd_expire && !wd_con_q[`CTW_WD_IRQOPT]) || wd_svc_bad)
            wd_chip_reset_q <= 1'b1;
      end
   end

endmodule

// ---- pkg/ctw_regs.vh ----
// register map, field positions, codes and reset values of the
// capture timer and watchdog block.
// assumes a 32-bit byte address on the register bus.
//
// Overview of operation
// - capture the count into the capture register on the event when bit 17 set
// - bits 16 to 12 pick the event; event number n is source n plus two
// - bits 11 to 9 pick core clock, crystal, undivided clock or pin edges
// - general timer counts up with bit 8 set, down when clear (reset)
// - general timer runs only while bit 7 is set; stopped after reset
// - bit 6 set reloads from load value at wrap; clear runs free
// - format bits 5 to 4: binary, or time of day wrapping at 23 or 255 hours
// - a write to the irq clear register clears the general timer irq unless a wrap sets it in that cycle
// - capture register is read-only, holds last captured count, resets to zero
// - second timer has a normal mode and a watchdog mode
// - normal mode: simple down timer with up option, 32 kHz source
// - second timer prescale bits 3 to 2: 1, 16, 256; code 11 acts as 00
// - second timer bit 6 set reloads at wrap; clear runs free
// - bit 5 enters watchdog mode, counting down from load value to zero
// - watchdog mode always counts the 32 kHz crystal
// - watchdog at zero raises irq if bit 1 set, else resets the chip
// - a watchdog clear write reloads the counter and starts a new timeout
// - in watchdog mode writes to load and control are ignored until reset
// - bit 4 enables the secure clear option; off by default
// - 16-bit load resets to zero; read-only count value resets to all ones
// - secure clear writes must match an 8-bit lfsr seeded before entry
// - a mismatching secure clear or a zero seed resets the chip at once
// - second timer counts up with bit 8 set in normal mode, down when clear or in watchdog mode
// - normal mode irq when down count hits zero or up count hits full scale
`ifndef CTW_REGS_VH
`define CTW_REGS_VH
// byte addresses
`define CTW_ADDR_GT_LOAD   32'hffff0320
`define CTW_ADDR_GT_VAL    32'hffff0324
`define CTW_ADDR_GT_CON    32'hffff0328
`define CTW_ADDR_GT_CLR    32'hffff032c
`define CTW_ADDR_GT_CAP    32'hffff0330
`define CTW_ADDR_WD_LOAD   32'hffff0360
`define CTW_ADDR_WD_VAL    32'hffff0364
`define CTW_ADDR_WD_CON    32'hffff0368
`define CTW_ADDR_WD_CLR    32'hffff036c
// general timer control fields
`define CTW_GT_CAP_EN      17
`define CTW_GT_EVT_HI      16
`define CTW_GT_EVT_LO      12
`define CTW_GT_SRC_HI      11
`define CTW_GT_SRC_LO      9
`define CTW_GT_UP          8
`define CTW_GT_EN          7
`define CTW_GT_PER         6
`define CTW_GT_FMT_HI      5
`define CTW_GT_FMT_LO      4
`define CTW_GT_PRE_HI      3
`define CTW_GT_PRE_LO      0
`define CTW_GT_CON_MASK    32'h0003ffff
`define CTW_EVT_OFFSET     6'h02
// source, format and prescale codes
`define CTW_SRC_CORE       3'h0
`define CTW_SRC_XTAL       3'h1
`define CTW_SRC_UNDIVIDED_SYSTEM_CLOCK       3'h2
`define CTW_SRC_PIN        3'h3
`define CTW_FMT_HMS23      2'h2
`define CTW_FMT_HMS255     2'h3
`define CTW_GT_PRE_16      4'h4
`define CTW_GT_PRE_256     4'h8
`define CTW_GT_PRE_32K     4'hf
`define CTW_GT_LIM_1       15'h0000
`define CTW_GT_LIM_16      15'h000f
`define CTW_GT_LIM_256     15'h00ff
`define CTW_GT_LIM_32K     15'h7fff
`define CTW_HUND_MAX       8'h63
`define CTW_SEC_MAX        8'h3b
`define CTW_HOUR_23        8'h17
`define CTW_HOUR_255       8'hff
// watchdog control fields
`define CTW_WD_UP          8
`define CTW_WD_EN          7
`define CTW_WD_PER         6
`define CTW_WD_MODE        5
`define CTW_WD_SEC         4
`define CTW_WD_PRE_HI      3
`define CTW_WD_PRE_LO      2
`define CTW_WD_IRQOPT      1
`define CTW_WD_CON_MASK    16'h01fe
`define CTW_WD_PRE_16      2'h1
`define CTW_WD_PRE_256     2'h2
`define CTW_WD_LIM_1       8'h00
`define CTW_WD_LIM_16      8'h0f
`define CTW_WD_LIM_256     8'hff
`define CTW_LFSR_TAPS      8'h63
// reset values
`define CTW_RST_GT_CON     32'h00000000
`define CTW_RST_GT_LOAD    32'h00000000
`define CTW_RST_GT_VAL     32'hffffffff
`define CTW_RST_GT_CAP     32'h00000000
`define CTW_RST_WD_LOAD    16'h0000
`define CTW_RST_WD_VAL     16'hffff
`define CTW_RST_WD_CON     16'h0000
// bus responses
`define CTW_RESP_OKAY      2'h0
`define CTW_RESP_SLVERR    2'h2
`endif

// ---- design/ctw_edge_sync.v ----
// two-flop synchroniser with a registered rising-edge pulse.
// assumes the input toggles slower than half of clk_sys.
`timescale 1ns/10ps
module ctw_edge_sync (
   // clock and reset
   input  wire clk_sys,
   input  wire rst_n,
   // asynchronous level in, one-cycle pulse out
   input  wire async_in,
   output reg  rise_q
);

   reg meta_q;
   reg sync_q;
   reg prev_q;

   ////////////////////////////////////////////////////////////////////////
   // meta_q feeds only sync_q; the edge is taken one stage later
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
         rise_q <= 1'b0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
         prev_q <= sync_q;
         rise_q <= sync_q & ~prev_q;
      end
   end

endmodule

// ---- verification/ctw_top_assertions.sv ----
// ctw_top checker: irq, chip reset and read data
// sees only ctw_top ports; writes are whole words
`timescale 1ns/10ps
`include "ctw_regs.vh"
module ctw_chk (
   // clock and reset
   input wire        clk_sys,
   input wire        rst_n,
   // bus
   input wire [31:0] s_axi_awaddr,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid,
   input wire [31:0] s_axi_araddr,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire        s_axi_rvalid,
   // outputs
   input wire        gt_irq_q,
   input wire        wd_irq_q,
   input wire        wd_chip_reset_q
);
   reg [31:0] aw_q, ar_q, w_q;
   reg        bv_q, en_q, wdm_q, cap_q;
   // write lands
   wire       fire = s_axi_bvalid & ~bv_q;
   wire       gc = fire && aw_q == `CTW_ADDR_GT_CON;
   wire       gk = fire && aw_q == `CTW_ADDR_GT_CLR;
   // enable shadows, one cycle late
   always @(posedge clk_sys) begin
      bv_q <= s_axi_bvalid & rst_n;
      if (s_axi_awvalid & s_axi_awready) aw_q <= s_axi_awaddr;
      if (s_axi_arvalid & s_axi_arready) ar_q <= s_axi_araddr;
      if (s_axi_wvalid & s_axi_wready) w_q <= s_axi_wdata;
      en_q <= rst_n & (gc ? w_q[7] : en_q);
      cap_q <= rst_n & (cap_q | (gc && w_q[17]));
      wdm_q <= rst_n & (wdm_q | (fire && aw_q == `CTW_ADDR_WD_CON && w_q[5]));
   end
   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   property p_boot; $rose(rst_n) |-> !gt_irq_q && !wd_irq_q; endproperty
   a_boot: assert property (p_boot)
      else $error("irq after reset");
   property p_run; $rose(gt_irq_q) |-> en_q || $past(en_q, 2); endproperty
   a_run: assert property (p_run)
      else $error("irq while stopped");
   property p_gtclr; gk |-> !gt_irq_q; endproperty
   a_gtclr: assert property (p_gtclr)
      else $error("gt irq not cleared");
   property p_wdclr;
      fire && aw_q == `CTW_ADDR_WD_CLR && !wd_chip_reset_q |-> !wd_irq_q;
   endproperty
   a_wdclr: assert property (p_wdclr)
      else $error("wd irq not cleared");
   property p_sticky; wd_chip_reset_q |=> wd_chip_reset_q [*8]; endproperty
   a_sticky: assert property (p_sticky)
      else $error("chip reset dropped");
   property p_wdrst; $rose(wd_chip_reset_q) |-> $past(wdm_q); endproperty
   a_wdrst: assert property (p_wdrst)
      else $error("reset outside watchdog");
   property p_hi0;
      s_axi_rvalid && ar_q[31:4] == 28'hffff036 |-> s_axi_rdata[31:16] == 0;
   endproperty
   a_hi0: assert property (p_hi0)
      else $error("wd read upper bits");
   property p_cap0;
      s_axi_rvalid && ar_q == `CTW_ADDR_GT_CAP && !cap_q |-> s_axi_rdata == 0;
   endproperty
   a_cap0: assert property (p_cap0)
      else $error("capture without enable");
   c_clr: cover property (gk);
   c_wdirq: cover property ($rose(wd_irq_q));
   c_rst: cover property ($rose(wd_chip_reset_q));
endmodule
bind ctw_top ctw_chk u_chk (.*);

// ---- verification/testbench.sv ----
// ctw_top bench: capture, irq, lock, secure clear
// needs the checker; fast crystal
`timescale 1ns/10ps
`include "ctw_regs.vh"
`define CHK(nm, e, s) comparisons++; if ((s) !== (e)) begin \
 n_mismatch++; $display("unexpected %s exp %h got %h", nm, e, s); end
module testbench;
   reg         clk_sys = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
   reg         s_axi_bready = 1, s_axi_arvalid = 0, s_axi_rready = 1;
   reg  [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, d, r;
   reg  [33:0] event_sources = 0;
   reg  [4:0]  xt = 0;
   reg  [7:0]  m;
   wire [2:0]  s_axi_awprot = 0, s_axi_arprot = 0;
   wire [3:0]  s_axi_wstrb = 4'hf;
   wire        undivided_system_clock = 0, external_count_pin = 0;
   wire        xtal_32k_in = xt[4];
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire        s_axi_rvalid, gt_irq_q, wd_irq_q, wd_chip_reset_q;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   int         n_mismatch = 0, comparisons = 0, i, n;
   // reset values
   reg  [31:0] ad [7] = '{`CTW_ADDR_GT_LOAD, `CTW_ADDR_GT_VAL,
      `CTW_ADDR_GT_CON, `CTW_ADDR_GT_CAP, `CTW_ADDR_WD_LOAD,
      `CTW_ADDR_WD_VAL, `CTW_ADDR_WD_CON};
   reg  [31:0] ex [7] = '{0, 32'hffffffff, 0, 0, 0, 32'h0000ffff, 0};
   ctw_top u_dut (.*);
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) xt <= xt + 5'h01;
   ////////////////////////////////////////////////////////////////////
   task stop_test;
      $display("mismatch %0d compare %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task tmo(input int k);
      if (k >= 2000) begin
         n_mismatch++;
         stop_test;
      end
   endtask
   // aw and w offered together, each dropped once when taken
   task automatic wr(input [31:0] a, input [31:0] v);
      int k;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      for (k = 0; k < 2000; k++) begin
         @(posedge clk_sys);
         if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 0;
         if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 0;
         if (s_axi_bvalid) break;
      end
      tmo(k);
   endtask
   task automatic rd(input [31:0] a);
      int k;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      for (k = 0; k < 2000; k++) begin
         @(posedge clk_sys);
         if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 0;
         if (s_axi_rvalid) break;
      end
      r = s_axi_rdata;
      tmo(k);
   endtask
   task reset_dut;
      rst_n <= 0;
      repeat (20) @(posedge clk_sys);
      rst_n <= 1;
      @(posedge clk_sys);
   endtask
   task pulse(input int b);
      event_sources <= 34'h1 << b;
      @(posedge clk_sys);
      event_sources <= 0;
      repeat (3) @(posedge clk_sys);
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h86e12494));
      reset_dut;
      for (i = 0; i < 7; i++) begin
         rd(ad[i]);
         `CHK("reset", ex[i], r)
      end
      // capture on offset line only
      d = $urandom;
      n = $urandom_range(31);
      wr(`CTW_ADDR_GT_CAP, d);
      wr(`CTW_ADDR_GT_LOAD, d);
      wr(`CTW_ADDR_GT_CON, 32'h20000 | (n << 12));
      pulse(n + 1);
      rd(`CTW_ADDR_GT_CAP);
      `CHK("capture idle", 32'h0, r)
      pulse(n + 2);
      rd(`CTW_ADDR_GT_CAP);
      `CHK("capture", d, r)
      // stop first so the clear wins
      wr(`CTW_ADDR_GT_LOAD, 3);
      wr(`CTW_ADDR_GT_CON, 32'hc0);
      for (i = 0; i < 2000 && gt_irq_q !== 1'b1; i++) @(posedge clk_sys);
      tmo(i);
      wr(`CTW_ADDR_GT_CON, 0);
      wr(`CTW_ADDR_GT_CLR, $urandom);
      `CHK("gt irq", 1'b0, gt_irq_q)
      // watchdog irq option; registers locked
      wr(`CTW_ADDR_WD_LOAD, 2);
      wr(`CTW_ADDR_WD_CON, 32'h22);
      for (i = 0; i < 2000 && wd_irq_q !== 1'b1; i++) @(posedge clk_sys);
      tmo(i);
      wr(`CTW_ADDR_WD_CON, 0);
      rd(`CTW_ADDR_WD_CON);
      `CHK("wd con", 32'h22, r)
      wr(`CTW_ADDR_WD_CLR, $urandom);
      `CHK("wd irq", 1'b0, wd_irq_q)
      // secure clear: a wrong lfsr value resets
      reset_dut;
      m = 8'($urandom) | 8'h01;
      wr(`CTW_ADDR_WD_CLR, m);
      wr(`CTW_ADDR_WD_LOAD, 32'h100);
      wr(`CTW_ADDR_WD_CON, 32'h32);
      for (i = 0; i < 3; i++) begin
         wr(`CTW_ADDR_WD_CLR, m);
         `CHK("chip reset", 1'b0, wd_chip_reset_q)
         m = {m[6:0], 1'b0} ^ (m[7] ? 8'h63 : 8'h00);
      end
      wr(`CTW_ADDR_WD_CLR, m ^ 8'h01);
      repeat (2) @(posedge clk_sys);
      `CHK("chip reset", 1'b1, wd_chip_reset_q)
      stop_test;
   end
endmodule
